// ---- verilog/discard_pkg.sv ----
`default_nettype none
package discard_pkg;

	// ********************************************
	// register indices (byte address = 4 * index)
	// ********************************************
	localparam logic [9:0] IDX_HOST_TRIG  = 10'h265;
	localparam logic [9:0] IDX_LOWER_TRIG = 10'h266;
	localparam logic [9:0] IDX_UPPER_TRIG = 10'h267;
	localparam logic [9:0] IDX_LOWER_CNT  = 10'h268;
	localparam logic [9:0] IDX_UPPER_CNT  = 10'h269;
	localparam logic [9:0] IDX_HOST_CNT   = 10'h26A;

	// ********************************************
	// bus layout and counter values
	// ********************************************
	localparam int         IDX_LSB        = 2;
	localparam int         MIN_ADDR_W     = 12;
	localparam int         MAX_ADDR_W     = 32;
	localparam logic [7:0] CNT_RESET      = 8'h00;
	localparam logic [7:0] CNT_MAX        = 8'hFF;
	localparam logic [7:0] CNT_ONE        = 8'h01;
	localparam logic [23:0] RD_PAD        = 24'h000000;

	// port numbering inside the counter arrays
	localparam int PORT_LOWER = 0;
	localparam int PORT_UPPER = 1;
	localparam int PORT_HOST  = 2;
	localparam int PORTS      = 3;

endpackage
`default_nettype wire

// ---- verilog/link_discard_frame_counters.sv ----
// Overview of operation
// (R1) lower-port response discards counted in 8 bits, read-only, zero after reset.
// (R2) reading lower trigger snapshots lower statistics together and clears counters.
// (R3) upper-port command discards counted in 8 bits, zero after reset.
// (R4) reading upper trigger snapshots upper statistics together and clears counters.
// (R5) host-port response discards counted in 8 bits, zero after reset.
// (R6) reading host trigger snapshots host statistics together and clears counters.
// (R7) discards caused by internal frame error never advance any counter.
// (R8) counters saturate at all ones until the trigger read clears them.
`timescale 1ns/10ps
`default_nettype none
module link_discard_frame_counters
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              ref_clk_i,
	input  wire logic              nrst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic              lower_resp_discard_i,
	input  wire logic              lower_resp_int_err_i,
	input  wire logic              upper_cmd_discard_i,
	input  wire logic              upper_cmd_int_err_i,
	input  wire logic              host_resp_discard_i,
	input  wire logic              host_resp_int_err_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	output logic                   lower_stats_update_o,
	output logic                   upper_stats_update_o,
	output logic                   host_stats_update_o
);

	// ********************************************
	// elaboration checks
	// ********************************************
	generate
		if (ADDR_W < discard_pkg::MIN_ADDR_W || ADDR_W > discard_pkg::MAX_ADDR_W)
		begin : g_bad_addr_w
			$error("address width cannot reach the register indices");
		end
	endgenerate

	// ********************************************
	// helpers
	// ********************************************

	// aligned word whose index matches
	function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		return (a[1:0] == 2'b00) && (a[ADDR_W-1:discard_pkg::IDX_LSB] == (ADDR_W-2)'(idx));
	endfunction

	// saturating step, holds at all ones
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == discard_pkg::CNT_MAX) ? v : v + discard_pkg::CNT_ONE;
	endfunction

	// ********************************************
	// declarations
	// ********************************************
	logic [2:0]       disc_w;
	logic [2:0]       int_err_w;
	logic [2:0]       event_w;
	logic [2:0]       trig_hit_w;
	logic [2:0]       trig_done_w;
	logic             setup_w;
	logic             done_w;
	logic [2:0][7:0]  live_r;
	logic [2:0][7:0]  live_nxt;
	logic [2:0][7:0]  snap_r;
	logic [2:0][7:0]  snap_nxt;
	logic [2:0]       upd_r;
	logic [2:0]       upd_nxt;
	logic [31:0]      prdata_r;
	logic [31:0]      prdata_nxt;
	logic             pready_r;
	logic             pready_nxt;
	logic             pslverr_r;
	logic             pslverr_nxt;

	// frame parser inputs share our clock, so no synchroniser
	assign disc_w = {host_resp_discard_i, upper_cmd_discard_i, lower_resp_discard_i};
	assign int_err_w = {host_resp_int_err_i, upper_cmd_int_err_i, lower_resp_int_err_i};

	// ********************************************
	// bus decode
	// ********************************************

	// phases of the current transfer
	assign setup_w = psel_i & ~penable_i;
	assign done_w  = psel_i & penable_i & pready_r;

	// trigger indices per port
	always_comb
	begin
		trig_hit_w[discard_pkg::PORT_LOWER] = idx_hit(paddr_i, discard_pkg::IDX_LOWER_TRIG);
		trig_hit_w[discard_pkg::PORT_UPPER] = idx_hit(paddr_i, discard_pkg::IDX_UPPER_TRIG);
		trig_hit_w[discard_pkg::PORT_HOST]  = idx_hit(paddr_i, discard_pkg::IDX_HOST_TRIG);
	end

	// (R2) (R4) (R6) trigger fires on read completion
	assign trig_done_w = {3{done_w & ~pwrite_i}} & trig_hit_w;

	// ********************************************
	// bus answer
	// ********************************************

	// answer prepared in setup, so access never waits
	always_comb
	begin
		pready_nxt  = setup_w;
		prdata_nxt  = 32'h00000000;
		pslverr_nxt = 1'b0;
		if (setup_w)
		begin
			// all registers are read-only, so writes are refused
			pslverr_nxt = pwrite_i;
			if (pwrite_i)
			begin
				prdata_nxt = 32'h00000000;
			end
			// (R1) lower count readable at its own address
			else if (idx_hit(paddr_i, discard_pkg::IDX_LOWER_CNT))
			begin
				prdata_nxt = {discard_pkg::RD_PAD, snap_r[discard_pkg::PORT_LOWER]};
			end
			// (R3) upper count readable
			else if (idx_hit(paddr_i, discard_pkg::IDX_UPPER_CNT))
			begin
				prdata_nxt = {discard_pkg::RD_PAD, snap_r[discard_pkg::PORT_UPPER]};
			end
			// (R5) host count readable
			else if (idx_hit(paddr_i, discard_pkg::IDX_HOST_CNT))
			begin
				prdata_nxt = {discard_pkg::RD_PAD, snap_r[discard_pkg::PORT_HOST]};
			end
			else if (|trig_hit_w)
			begin
				// trigger contents belong to neighbouring logic
				prdata_nxt = 32'h00000000;
			end
			else
			begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	// bus answer registers
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ********************************************
	// discard counters
	// ********************************************

	// (R7) internal frame error discards are not counted
	assign event_w = disc_w & ~int_err_w;

	// live count, snapshot and update strobe per port
	always_comb
	begin
		live_nxt = live_r;
		snap_nxt = snap_r;
		upd_nxt  = trig_done_w;
		for (int p = 0; p < discard_pkg::PORTS; p++)
		begin
			if (trig_done_w[p])
			begin
				// (R2) (R4) (R6) snapshot and clear in one edge
				snap_nxt[p] = live_r[p];
				// a discard in the clear cycle opens the new interval
				live_nxt[p] = event_w[p] ? discard_pkg::CNT_ONE : discard_pkg::CNT_RESET;
			end
			else if (event_w[p])
			begin
				// (R8) saturating step
				live_nxt[p] = sat_inc(live_r[p]);
			end
		end
	end

	// (R1) (R3) (R5) counters zero after reset
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			live_r <= {discard_pkg::PORTS{discard_pkg::CNT_RESET}};
			snap_r <= {discard_pkg::PORTS{discard_pkg::CNT_RESET}};
			upd_r  <= 3'b000;
		end
		else
		begin
			live_r <= live_nxt;
			snap_r <= snap_nxt;
			upd_r  <= upd_nxt;
		end
	end

	// ********************************************
	// outputs
	// ********************************************

	// update strobes tell neighbouring counters to snapshot too
	assign prdata_o             = prdata_r;
	assign pready_o             = pready_r;
	assign pslverr_o            = pslverr_r;
	assign lower_stats_update_o = upd_r[discard_pkg::PORT_LOWER];
	assign upper_stats_update_o = upd_r[discard_pkg::PORT_UPPER];
	assign host_stats_update_o  = upd_r[discard_pkg::PORT_HOST];

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence rd_setup_s(logic [9:0] idx);
		setup_w && !pwrite_i && idx_hit(paddr_i, idx);
	endsequence

	sequence rd_answer_s(logic [7:0] v);
		pready_o && !pslverr_o && prdata_o == {discard_pkg::RD_PAD, v};
	endsequence

	// bus answers in the access cycle only
	bus_ready_a: assert property (setup_w |=> pready_o ##1 !pready_o)
		else $error("ready not a single cycle after setup");

	// (R1) lower count read
	lower_read_a: assert property ( // (R1)
		rd_setup_s(discard_pkg::IDX_LOWER_CNT) |=> rd_answer_s($past(snap_r[0])))
		else $error("lower count read wrong");

	// (R2) lower snapshot and clear
	lower_snap_a: assert property ( // (R2)
		trig_done_w[0] |=> snap_r[0] == $past(live_r[0]) && lower_stats_update_o
		&& live_r[0] == ($past(event_w[0]) ? 8'h01 : 8'h00))
		else $error("lower snapshot or clear wrong");

	// (R3) upper count read
	upper_read_a: assert property ( // (R3)
		rd_setup_s(discard_pkg::IDX_UPPER_CNT) |=> rd_answer_s($past(snap_r[1])))
		else $error("upper count read wrong");

	// (R4) upper snapshot and clear
	upper_snap_a: assert property ( // (R4)
		trig_done_w[1] && !event_w[1] |=> live_r[1] == 8'h00
		&& snap_r[1] == $past(live_r[1]) && upper_stats_update_o)
		else $error("upper snapshot or clear wrong");

	// (R5) host count read
	host_read_a: assert property ( // (R5)
		rd_setup_s(discard_pkg::IDX_HOST_CNT) |=> rd_answer_s($past(snap_r[2])))
		else $error("host count read wrong");

	// (R6) host snapshot leaves the lower port alone
	host_snap_a: assert property ( // (R6)
		trig_done_w[2] |=> snap_r[2] == $past(live_r[2]) && host_stats_update_o
		&& $stable(snap_r[0]) && !lower_stats_update_o)
		else $error("host snapshot wrong");

	// (R7) errored discards leave the lower count alone
	err_skip_a: assert property ( // (R7)
		disc_w[0] && int_err_w[0] && !trig_done_w[0] |=> $stable(live_r[0]))
		else $error("lower counted an internal error discard");

	// (R7) same guard on the host port
	host_err_skip_a: assert property ( // (R7)
		disc_w[2] && int_err_w[2] && !trig_done_w[2] |=> $stable(live_r[2]))
		else $error("host counted an internal error discard");

	// (R1) read-only, so a write is refused and no snapshot moves
	wr_refuse_a: assert property ( // (R1)
		setup_w && pwrite_i |=> pready_o && pslverr_o && $stable(snap_r))
		else $error("write to a read-only register accepted");

	// (R6) update strobe lasts a single cycle
	host_pulse_a: assert property ( // (R6)
		host_stats_update_o |=> !host_stats_update_o)
		else $error("host update strobe longer than one cycle");

	// (R8) saturation holds
	sat_hold_a: assert property ( // (R8)
		live_r[1] == 8'hFE && event_w[1] && !trig_done_w[1]
		##1 event_w[1] && !trig_done_w[1] |=> live_r[1] == 8'hFF)
		else $error("upper counter wrapped");

endmodule // link_discard_frame_counters
`default_nettype wire

// ---- sim/frame_discard_source.sv ----
`timescale 1ns/10ps
`default_nettype none
// ******
// far-side frame parsers
// ******
module frame_discard_source
(
	input  wire logic       ref_clk_i,
	input  wire logic [1:0] mode_i,
	output logic [2:0]      discard_o,
	output logic [2:0]      int_err_o
);
	int seed = 32'h42BE;
	// 0 idle, 1 random, 2 clean flood, 3 flood all with internal error
	always @(posedge ref_clk_i)
	begin
		discard_o <= (mode_i == 2'h1) ? 3'($random(seed)) : {3{mode_i[1]}};
		// error cause on about a quarter of random discards
		int_err_o <= (mode_i == 2'h1) ? 3'($random(seed) & $random(seed)) : {3{mode_i[0]}};
	end
endmodule // frame_discard_source
`default_nettype wire

// ---- sim/link_discard_frame_counters_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// ******
// bench top
// ******
module link_discard_frame_counters_tb;
	logic        ref_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic [2:0]  disc;
	logic [2:0]  int_err;
	logic [2:0]  upd;
	logic [2:0]  pend;
	logic [1:0]  mode = 2'h0;
	logic [7:0]  live [3];
	logic [7:0]  snap [3];
	logic [31:0] rd;
	logic        err;
	int          seed = 32'h42BE;
	int          error_cnt = 0;
	int          check_count = 0;
	// index order follows the package port numbering: lower, upper, host
	logic [9:0]  trig [3] = '{discard_pkg::IDX_LOWER_TRIG, discard_pkg::IDX_UPPER_TRIG,
		discard_pkg::IDX_HOST_TRIG};
	logic [9:0]  cnt [3] = '{discard_pkg::IDX_LOWER_CNT, discard_pkg::IDX_UPPER_CNT,
		discard_pkg::IDX_HOST_CNT};
	logic [11:0] bad [3] = '{12'h990, 12'h9AC, 12'h9A1};

	always #20 ref_clk_i = ~ref_clk_i;

	link_discard_frame_counters i_link_discard_frame_counters
	(
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.lower_resp_discard_i(disc[0]), .lower_resp_int_err_i(int_err[0]),
		.upper_cmd_discard_i(disc[1]), .upper_cmd_int_err_i(int_err[1]),
		.host_resp_discard_i(disc[2]), .host_resp_int_err_i(int_err[2]),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.lower_stats_update_o(upd[0]), .upper_stats_update_o(upd[1]),
		.host_stats_update_o(upd[2])
	);
	frame_discard_source i_frame_discard_source
	(
		.ref_clk_i(ref_clk_i), .mode_i(mode), .discard_o(disc), .int_err_o(int_err)
	);

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// reference counters, sampled at the same edges as the design
	always @(posedge ref_clk_i)
	begin
		for (int p = 0; p < 3; p++)
		begin
			if (nrst_i !== 1'b1)
			begin
				live[p] = 8'h00;
				snap[p] = 8'h00;
				pend[p] = 1'b0;
			end
			else
			begin
				check("stats_update", {31'h0, upd[p]}, {31'h0, pend[p]});
				pend[p] = psel_i & penable_i & pready_o & ~pwrite_i & (paddr_i == {trig[p], 2'b00});
				if (pend[p])
				begin
					snap[p] = live[p];
					live[p] = {7'h00, disc[p] & ~int_err[p]};
				end
				else if (disc[p] & ~int_err[p])
					live[p] = sat_inc(live[p]);
			end
		end
	end

	// one transfer, then one idle edge so the next setup never collides
	task automatic apb(input logic wr, input logic [11:0] addr);
		int   n;
		logic got;
		n = 0;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= addr;
		pwdata_i <= $random(seed);
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 8);
		got = pready_o;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge ref_clk_i);
		if (got !== 1'b1)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask

	task automatic read_cnt(input int p);
		apb(1'b0, {cnt[p], 2'b00});
		check("count", rd, {24'h000000, snap[p]});
		check("count_err", {31'h0, err}, 32'h00000000);
	endtask

	task automatic trigger(input int p);
		apb(1'b0, {trig[p], 2'b00});
		check("trigger_data", rd, 32'h00000000);
		check("trigger_err", {31'h0, err}, 32'h00000000);
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		for (int p = 0; p < 3; p++)
			read_cnt(p);
		for (int r = 0; r < 8; r++)
		begin
			// round 0 error-only flood, round 1 floods past 255, rest random
			mode <= (r == 0) ? 2'h3 : (r == 1) ? 2'h2 : 2'h1;
			repeat ((r == 1) ? 300 : 20 + ($random(seed) & 63)) @(posedge ref_clk_i);
			for (int k = 0; k < 3; k++)
				trigger((k + r) % 3);
			for (int p = 0; p < 3; p++)
				read_cnt(p);
			apb(1'b1, {cnt[r % 3], 2'b00});
			check("write_err", {31'h0, err}, 32'h00000001);
			read_cnt(r % 3);
		end
		for (int b = 0; b < 3; b++)
		begin
			apb(1'b0, bad[b]);
			check("bad_err", {31'h0, err}, 32'h00000001);
			check("bad_data", rd, 32'h00000000);
		end
		nrst_i <= 1'b0;
		mode <= 2'h0;
		repeat (2) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		for (int p = 0; p < 3; p++)
		begin
			trigger(p);
			read_cnt(p);
		end
		print_verdict();
	end
endmodule // link_discard_frame_counters_tb
`default_nettype wire
